// ===== dv/rssk_exec_assertions.sv
// checker for the rotate, subtract and skip slice
`timescale 1ns/100ps
`default_nettype none
module rssk_exec_chk
    import rssk_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       op_valid,
    input wire logic [2:0] op_code,
    input wire rssk_byte_t mem_rdata,
    input wire logic       mem_we,
    input wire rssk_byte_t mem_wdata,
    input wire rssk_byte_t acc,
    input wire logic       carry_flag,
    input wire logic       zero_flag,
    input wire logic       nibble_carry_flag,
    input wire logic       signed_range_flag,
    input wire logic       skip_next,
    input wire logic       busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic       go;
    logic [8:0] sdiff;
    assign go = op_valid && !busy;
    // sign-extended difference: bits 8 and 7 differ on signed overflow
    assign sdiff = {acc[7], acc} - {mem_rdata[7], mem_rdata} - {8'h00, !carry_flag};
    a_rot_mem: assert property (go && op_code == 3'h1 |=> mem_we
        && carry_flag == $past(mem_rdata[0])
        && mem_wdata == {$past(carry_flag), $past(mem_rdata[7:1])}) else $error("rot mem");
    a_rot_acc: assert property (go && op_code == 3'h2 |=> !mem_we
        && acc == {$past(carry_flag), $past(mem_rdata[7:1])}) else $error("rot acc");
    a_sub_acc: assert property (go && op_code == 3'h3 |=> !mem_we
        && zero_flag == (acc == 8'h00)
        && acc == $past(acc) - $past(mem_rdata) - !$past(carry_flag)) else $error("sub acc");
    a_sub_carry: assert property (go && (op_code == 3'h3 || op_code == 3'h4) |=>
        carry_flag == ({1'b0, $past(acc)} >= {1'b0, $past(mem_rdata)} + !$past(carry_flag)))
        else $error("borrow");
    a_sub_ovf: assert property (go && (op_code == 3'h3 || op_code == 3'h4) |=>
        signed_range_flag == ($past(sdiff[8]) != $past(sdiff[7]))) else $error("overflow");
    a_sub_nibble: assert property (go && (op_code == 3'h3 || op_code == 3'h4) |=>
        nibble_carry_flag == ({1'b0, $past(acc[3:0])} >= {1'b0, $past(mem_rdata[3:0])}
        + !$past(carry_flag))) else $error("nibble");
    a_sub_mem: assert property (go && op_code == 3'h4 |=> mem_we && $stable(acc)
        && mem_wdata == $past(acc) - $past(mem_rdata) - !$past(carry_flag)) else $error("sub mem");
    a_skip_dummy: assert property (go && op_code == 3'h5 && mem_rdata == 8'h01 |=>
        skip_next && busy ##1 !busy && !mem_we) else $error("skip");
    a_dec_noskip: assert property (go && op_code == 3'h5 && mem_rdata != 8'h01 |=>
        !skip_next && !busy) else $error("no skip");
    a_dec_flags: assert property (go && op_code == 3'h5 |=> mem_we && $stable(acc)
        && mem_wdata == $past(mem_rdata) - 8'h01
        && $stable({carry_flag, zero_flag, nibble_carry_flag, signed_range_flag}))
        else $error("dec");
endmodule
bind rssk_exec rssk_exec_chk u_chk (.ref_clk, .rst_b, .op_valid, .op_code, .mem_rdata, .mem_we,
    .mem_wdata, .acc, .carry_flag, .zero_flag, .nibble_carry_flag, .signed_range_flag,
    .skip_next, .busy);
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the execution slice
`timescale 1ns/100ps
`default_nettype none
module testbench
    import rssk_pkg::*;
;
    logic        ref_clk, rst_b, op_valid, mem_we, skip_next, busy, v_q, dum;
    logic        carry_flag, zero_flag, nibble_carry_flag, signed_range_flag;
    logic        m_c, m_z, m_n, m_o;
    logic [2:0]  op_code;
    rssk_byte_t  mem_rdata, mem_wdata, acc, m_acc, m_wd;
    logic [22:0] q[$];
    logic [22:0] outs;
    logic [31:0] seed, r;
    int          num_errors, checked;
    assign outs = {acc, carry_flag, zero_flag, nibble_carry_flag, signed_range_flag,
                   mem_we, mem_wdata, skip_next, busy};
    rssk_exec dut (.ref_clk, .rst_b, .op_valid, .op_code, .mem_rdata, .mem_we, .mem_wdata, .acc,
        .carry_flag, .zero_flag, .nibble_carry_flag, .signed_range_flag, .skip_next, .busy);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [22:0] seen, input logic [22:0] want);
        checked++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic op(input logic [2:0] c, input rssk_byte_t d);
        logic [8:0] t;
        logic [4:0] n;
        logic       we;
        logic       sk;
        we = 1'b0;
        sk = 1'b0;
        t = {1'b0, m_acc} - {1'b0, d} - {8'h00, !m_c};
        n = {1'b0, m_acc[3:0]} - {1'b0, d[3:0]} - {4'h0, !m_c};
        if (dum) begin
            dum = 1'b0;
        end else if (c == 3'h1 || c == 3'h2) begin
            if (c == 3'h1) {we, m_wd} = {1'b1, m_c, d[7:1]};
            else m_acc = {m_c, d[7:1]};
            m_c = d[0];
        end else if (c == 3'h3 || c == 3'h4) begin
            m_o = (m_acc[7] != d[7]) && (t[7] != m_acc[7]);
            if (c == 3'h3) m_acc = t[7:0];
            else {we, m_wd} = {1'b1, t[7:0]};
            {m_c, m_z, m_n} = {!t[8], t[7:0] == 8'h00, !n[4]};
        end else if (c == 3'h5) begin
            {we, m_wd} = {1'b1, d - 8'h01};
            sk = (d == 8'h01);
            dum = sk;
        end
        q.push_back({m_acc, m_c, m_z, m_n, m_o, we, m_wd, sk, sk});
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op_code <= c;
        mem_rdata <= d;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) v_q <= op_valid;
    always @(negedge ref_clk) begin
        if (v_q) begin
            check(outs, q.pop_front());
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #50000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {rst_b, op_valid, op_code, mem_rdata, dum} = '0;
        {m_acc, m_wd, m_c, m_z, m_n, m_o} = '0;
        seed = 32'h4f;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        check(outs, 23'h0);
        op(3'h5, 8'h01);
        op(3'h1, 8'hff);
        op(3'h5, 8'h00);
        op(3'h4, 8'h80);
        $display("test directed done");
        repeat (400) begin
            r = rnd();
            op(r[2:0], r[9] ? 8'h01 : r[31:24]);
        end
        $display("test random done");
        @(posedge ref_clk);
        op_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ===== hw/rssk_consts.svh
// constants for the rotate, subtract and skip execution slice
`ifndef RSSK_CONSTS_SVH
`define RSSK_CONSTS_SVH
`define RSSK_OP_W        3
`define RSSK_OP_NONE     3'h0
`define RSSK_OP_RRC_MEM  3'h1
`define RSSK_OP_RRC_ACC  3'h2
`define RSSK_OP_SBW_ACC  3'h3
`define RSSK_OP_SBW_MEM  3'h4
`define RSSK_OP_DSZ      3'h5
`define RSSK_DATA_W      8
`define RSSK_ACC_RST     8'h00
`define RSSK_FLAG_RST    1'b0
`define RSSK_MSB         7
`define RSSK_NIB_MSB     3
`endif

// ===== hw/rssk_exec.sv
// execution slice: rotate through carry, subtract with borrow, decrement and skip
//
`timescale 1ns/100ps
`default_nettype none
`include "rssk_consts.svh"
module rssk_exec
    import rssk_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       op_valid,
    input  wire logic [2:0] op_code,
    input  wire rssk_byte_t mem_rdata,
    output var  logic       mem_we,
    output var  rssk_byte_t mem_wdata,
    output var  rssk_byte_t acc,
    output var  logic       carry_flag,
    output var  logic       zero_flag,
    output var  logic       nibble_carry_flag,
    output var  logic       signed_range_flag,
    output var  logic       skip_next,
    output var  logic       busy
);

    ////////////////////////////////////////////////////////////////////////
    // arithmetic helpers

    // returns {no_borrow, diff}
    function automatic logic [8:0] sub_borrow(input rssk_byte_t a, input rssk_byte_t b,
                                              input logic c);
        logic [8:0] full;
        full = {1'b0, a} - {1'b0, b} - {8'h00, ~c};
        sub_borrow = {~full[8], full[7:0]};
    endfunction

    function automatic logic nib_no_borrow(input rssk_byte_t a, input rssk_byte_t b,
                                           input logic c);
        logic [4:0] n;
        n = {1'b0, a[`RSSK_NIB_MSB:0]} - {1'b0, b[`RSSK_NIB_MSB:0]} - {4'h0, ~c};
        nib_no_borrow = ~n[4];
    endfunction

    // both rotate forms: old carry enters the top bit
    function automatic rssk_byte_t rot_right(input rssk_byte_t v, input logic c);
        rot_right = {c, v[`RSSK_MSB:1]};
    endfunction

    // operand signs differ and the result sign leaves the minuend's
    function automatic logic sub_ovf(input rssk_byte_t a, input rssk_byte_t b,
                                     input rssk_byte_t d);
        sub_ovf = (a[`RSSK_MSB] != b[`RSSK_MSB]) && (d[`RSSK_MSB] != a[`RSSK_MSB]);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // datapath and flag state

    rssk_state_e st_d;
    rssk_state_e st_q;
    rssk_byte_t  acc_d;
    rssk_byte_t  acc_q;
    logic        c_d;
    logic        c_q;
    logic        z_d;
    logic        z_q;
    logic        ac_d;
    logic        ac_q;
    logic        ov_d;
    logic        ov_q;
    logic        skip_d;
    logic        skip_q;
    logic        busy_d;
    logic        busy_q;
    logic        wr_en;
    rssk_byte_t  wr_data;
    logic [8:0]  sub_res;
    rssk_byte_t  dec_val;
    logic        skip_req;

    always_comb begin
        acc_d   = acc_q;
        c_d     = c_q;
        z_d     = z_q;
        ac_d    = ac_q;
        ov_d    = ov_q;
        skip_req = 1'b0;
        wr_en   = 1'b0;
        wr_data = 8'h00;
        sub_res = sub_borrow(acc_q, mem_rdata, c_q);
        dec_val = mem_rdata - 8'h01;
        case (st_q)
            RSSK_ST_RUN: begin
                if (op_valid) begin
                    case (op_code)
                        `RSSK_OP_RRC_MEM: begin
                            wr_en   = 1'b1;
                            wr_data = rot_right(mem_rdata, c_q);
                            c_d     = mem_rdata[0];
                        end
                        `RSSK_OP_RRC_ACC: begin
                            acc_d = rot_right(mem_rdata, c_q);
                            c_d   = mem_rdata[0];
                        end
                        `RSSK_OP_SBW_ACC, `RSSK_OP_SBW_MEM: begin
                            c_d  = sub_res[8];
                            z_d  = (sub_res[7:0] == 8'h00);
                            ac_d = nib_no_borrow(acc_q, mem_rdata, c_q);
                            ov_d = sub_ovf(acc_q, mem_rdata, sub_res[`RSSK_MSB:0]);
                            if (op_code == `RSSK_OP_SBW_ACC) begin
                                acc_d = sub_res[7:0];
                            end else begin
                                wr_en   = 1'b1;
                                wr_data = sub_res[7:0];
                            end
                        end
                        `RSSK_OP_DSZ: begin
                            wr_en   = 1'b1;
                            wr_data = dec_val;
                            // flags untouched, no skip when nonzero
                            if (dec_val == 8'h00) begin
                                // zero result asks for a skip
                                skip_req = 1'b1;
                            end
                        end
                        default: begin
                            wr_en = 1'b0;
                        end
                    endcase
                end
            end
            default: begin
                // the dummy cycle takes no operand
                wr_en = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= `RSSK_ACC_RST;
            c_q   <= `RSSK_FLAG_RST;
            z_q   <= `RSSK_FLAG_RST;
            ac_q  <= `RSSK_FLAG_RST;
            ov_q  <= `RSSK_FLAG_RST;
        end else begin
            acc_q <= acc_d;
            c_q   <= c_d;
            z_q   <= z_d;
            ac_q  <= ac_d;
            ov_q  <= ov_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // skip sequencer

    always_comb begin
        st_d   = st_q;
        skip_d = 1'b0;
        busy_d = 1'b0;
        case (st_q)
            RSSK_ST_RUN: begin
                if (skip_req) begin
                    skip_d = 1'b1;
                    busy_d = 1'b1;
                    st_d   = RSSK_ST_DUMMY;
                end
            end
            RSSK_ST_DUMMY: begin
                st_d = RSSK_ST_RUN;
            end
            default: begin
                st_d = RSSK_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q   <= RSSK_ST_RUN;
            skip_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            skip_q <= skip_d;
            busy_q <= busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory write register

    rssk_result_reg u_result (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .wr_en     (wr_en),
        .wr_data   (wr_data),
        .mem_we    (mem_we),
        .mem_wdata (mem_wdata)
    );

    assign acc               = acc_q;
    assign carry_flag        = c_q;
    assign zero_flag         = z_q;
    assign nibble_carry_flag = ac_q;
    assign signed_range_flag = ov_q;
    assign skip_next         = skip_q;
    assign busy              = busy_q;
endmodule
`default_nettype wire

// ===== hw/rssk_pkg.sv
// types for the rotate, subtract and skip execution slice
package rssk_pkg;
    typedef enum logic [1:0] {
        RSSK_ST_RUN   = 2'b01,
        RSSK_ST_DUMMY = 2'b10
    } rssk_state_e;
    typedef logic [7:0] rssk_byte_t;
endpackage

// ===== hw/rssk_result_reg.sv
// result holding register for memory write data and the write strobe
`timescale 1ns/100ps
`default_nettype none
`include "rssk_consts.svh"
module rssk_result_reg
    import rssk_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       wr_en,
    input  wire rssk_byte_t wr_data,
    output var  logic       mem_we,
    output var  rssk_byte_t mem_wdata
);
    logic       we_d;
    logic       we_q;
    rssk_byte_t data_d;
    rssk_byte_t data_q;

    always_comb begin
        we_d   = wr_en;
        data_d = wr_en ? wr_data : data_q;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            we_q   <= 1'b0;
            data_q <= 8'h00;
        end else begin
            we_q   <= we_d;
            data_q <= data_d;
        end
    end

    assign mem_we    = we_q;
    assign mem_wdata = data_q;
endmodule
`default_nettype wire
